// [hdl/cdc_params.svh]
// Contract
// - word bits 12..8 carry register address
// - word bits 7..0 carry register data
// - bit 13 zero writes, one reads
// - page 00 address 1/2; reset zero
// - control one bit 7 soft reset
// - control one bit 6 power-down
// - control one bit 5 digital loopback
// - control one bit 4 analog loopback
// - control one bit 3 monitor source
// - control one bits 2..0 monitor gain
// - gain two bits 7..5 line input gain
// - gain two bits 4..2 DAC gain
// - gain two bit 1 speaker on
// - gain two bit 0 overflow, read-only
`ifndef CDC_PARAMS_SVH
`define CDC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
`define CDC_WORD_W       16
`define CDC_WORD_BITS    5'h10
`define CDC_PAGE_MSB     15
`define CDC_PAGE_LSB     14
`define CDC_PAGE_VAL     2'h0
`define CDC_RW_BIT       13
`define CDC_ADDR_MSB     12
`define CDC_ADDR_LSB     8
`define CDC_DATA_MSB     7
`define CDC_DATA_LSB     0
`define CDC_REG_CTRL_ONE 5'h01
`define CDC_REG_GAIN_TWO 5'h02
`define CDC_REG_RST      8'h00

////////////////////////////////////////////////////////////////////////////
`define CDC_SWRST_BIT    7
`define CDC_PWDN_BIT     6
`define CDC_DLB_BIT      5
`define CDC_ALB_BIT      4
`define CDC_MONSRC_BIT   3
`define CDC_MONG_MSB     2
`define CDC_MONG_LSB     0
`define CDC_LING_MSB     7
`define CDC_LING_LSB     5
`define CDC_DACG_MSB     4
`define CDC_DACG_LSB     2
`define CDC_SPK_BIT      1
`define CDC_OVF_BIT      0

////////////////////////////////////////////////////////////////////////////
`define CDC_MON_MUTE     3'h0
`define CDC_MON_MAX      3'h5
`define CDC_PGA_MUTE     3'h4
`define CDC_MON_STEP_DB  6'sh03
`define CDC_PGA_STEP_DB  6'sh06
`define CDC_DB_ZERO      6'sh00

`endif

// [hdl/cdc_pkg.sv]
`include "cdc_params.svh"

package cdc_pkg;

    typedef logic [`CDC_WORD_W-1:0] cdc_word_t;
    typedef logic signed [5:0]      cdc_db_t;

    typedef struct packed {
        logic [4:0] cnt;
        cdc_word_t  rx;
        cdc_word_t  tx;
        cdc_word_t  pend;
        cdc_word_t  word;
        logic       req_tgl;
        logic       ack_seen;
    } cdc_link_st_t;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:1] gain_two;
        logic       req_seen;
        logic       ack_tgl;
        cdc_word_t  reply;
        logic       mon_mute;
        cdc_db_t    mon_db;
        logic       line_mute;
        cdc_db_t    line_db;
        logic       dac_mute;
        cdc_db_t    dac_db;
    } cdc_regs_st_t;

endpackage : cdc_pkg

// [hdl/cdc_sync.sv]
`timescale 1ns/100ps

module cdc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);
    import cdc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } cdc_sync_st_t;

    cdc_sync_st_t q;
    cdc_sync_st_t d;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second; a change counts once two and
    // three agree, so a metastable settle cannot glitch the level
    always_comb begin
        d     = q;
        d.s1  = async_in;
        d.s2  = q.s1;
        d.s3  = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.lvl;

endmodule : cdc_sync

// [hdl/cdc_link.sv]
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_link (
    input  wire logic      sclk,
    input  wire logic      resetn,
    input  wire logic      fs_n,
    input  wire logic      din,
    output logic           dout,
    output logic           dout_oe,
    output cdc_pkg::cdc_word_t word_out,
    output logic           req_tgl,
    input  wire cdc_pkg::cdc_word_t reply_word,
    input  wire logic      ack_lvl
);
    import cdc_pkg::*;

    cdc_link_st_t q;
    cdc_link_st_t d;

    ////////////////////////////////////////////////////////////////////////
    // serial clock is assumed free running; the bit count restarts on
    // every edge seen with the frame sync high
    always_comb begin
        d = q;
        if (ack_lvl != q.ack_seen) begin
            d.ack_seen = ack_lvl;
            d.pend     = reply_word;
        end
        if (fs_n) begin
            d.cnt = 5'h00;
            d.tx  = d.pend;
        end else if (q.cnt != `CDC_WORD_BITS) begin
            d.rx  = {q.rx[`CDC_WORD_W-2:0], din};
            d.tx  = {q.tx[`CDC_WORD_W-2:0], 1'b0};
            d.cnt = q.cnt + 5'h01;
            // bits beyond the sixteenth are ignored until sync rises
            if (q.cnt == `CDC_WORD_BITS - 5'h01) begin
                d.word    = d.rx;
                d.req_tgl = ~q.req_tgl;
            end
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout     = q.tx[`CDC_WORD_W-1];
    assign dout_oe  = ~fs_n;
    assign word_out = q.word;
    assign req_tgl  = q.req_tgl;

endmodule : cdc_link

// [hdl/cdc_ctrl_regs.sv]
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_ctrl_regs (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        sclk,
    input  wire logic        fs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    input  wire logic        adc_overflow,
    output logic             soft_reset,
    output logic             power_down,
    output logic             dig_loopback,
    output logic             ana_loopback,
    output logic             mon_src_line,
    output logic [2:0]       mon_gain_code,
    output logic             mon_mute,
    output cdc_pkg::cdc_db_t mon_gain_db,
    output logic [2:0]       line_input_pga_gain,
    output logic             line_input_pga_mute,
    output cdc_pkg::cdc_db_t line_input_pga_db,
    output logic [2:0]       dac_pga_gain,
    output logic             dac_pga_mute,
    output cdc_pkg::cdc_db_t dac_pga_db,
    output logic             spk_gain_on
);
    import cdc_pkg::*;

    cdc_regs_st_t q;
    cdc_regs_st_t d;

    cdc_word_t    link_word;
    logic         link_req;
    logic         req_lvl;
    logic         ack_lvl;
    logic [4:0]   acc_addr;
    logic [7:0]   acc_data;
    logic [7:0]   rd_byte;
    logic         acc_page_ok;
    logic         acc_read;

    ////////////////////////////////////////////////////////////////////////
    // undefined codes are muted rather than left to an analog guess
    function automatic logic mon_is_mute(input logic [2:0] c);
        return (c == `CDC_MON_MUTE) || (c > `CDC_MON_MAX);
    endfunction : mon_is_mute

    function automatic cdc_db_t mon_db_of(input logic [2:0] c);
        cdc_db_t v;
        v = `CDC_DB_ZERO;
        if (!mon_is_mute(c)) begin
            v = ($signed({3'h0, c}) - 6'sh01) * `CDC_MON_STEP_DB;
        end
        return v;
    endfunction : mon_db_of

    function automatic logic pga_is_mute(input logic [2:0] c);
        return c >= `CDC_PGA_MUTE;
    endfunction : pga_is_mute

    function automatic cdc_db_t pga_db_of(input logic [2:0] c,
                                          input logic       neg);
        cdc_db_t v;
        v = `CDC_DB_ZERO;
        if (!pga_is_mute(c)) begin
            v = $signed({3'h0, c}) * `CDC_PGA_STEP_DB;
            if (neg) begin
                v = -v;
            end
        end
        return v;
    endfunction : pga_db_of

    ////////////////////////////////////////////////////////////////////////
    // link side runs on the serial clock; words cross by a toggle plus a
    // word held steady until the toggle has been seen
    cdc_link u_link (
        .sclk       (sclk),
        .resetn     (resetn),
        .fs_n       (fs_n),
        .din        (din),
        .dout       (dout),
        .dout_oe    (dout_oe),
        .word_out   (link_word),
        .req_tgl    (link_req),
        .reply_word (q.reply),
        .ack_lvl    (ack_lvl)
    );

    cdc_sync #(.W(1)) u_req_sync (
        .clk       (mclk),
        .rst_n     (resetn),
        .async_in  (link_req),
        .level_out (req_lvl)
    );

    cdc_sync #(.W(1)) u_ack_sync (
        .clk       (sclk),
        .rst_n     (resetn),
        .async_in  (q.ack_tgl),
        .level_out (ack_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // link_word is stable for a whole frame after the toggle, so the
    // four-cycle sync delay leaves ample margin to read it here
    assign acc_addr    = link_word[`CDC_ADDR_MSB:`CDC_ADDR_LSB];
    assign acc_data    = link_word[`CDC_DATA_MSB:`CDC_DATA_LSB];
    assign acc_read    = link_word[`CDC_RW_BIT];
    assign acc_page_ok = link_word[`CDC_PAGE_MSB:`CDC_PAGE_LSB]
                         == `CDC_PAGE_VAL;

    always_comb begin
        d = q;
        rd_byte = 8'h00;
        if (req_lvl != q.req_seen) begin
            d.req_seen = req_lvl;
            if (acc_page_ok && !acc_read) begin
                case (acc_addr)
                    `CDC_REG_CTRL_ONE: begin
                        d.ctrl_one = acc_data;
                    end
                    `CDC_REG_GAIN_TWO: begin
                        // overflow bit is not stored: writes to it drop
                        d.gain_two = acc_data[7:1];
                    end
                    default: begin
                        d.gain_two = q.gain_two;
                    end
                endcase
            end
            if (acc_page_ok) begin
                case (acc_addr)
                    `CDC_REG_CTRL_ONE: begin
                        rd_byte = d.ctrl_one;
                    end
                    `CDC_REG_GAIN_TWO: begin
                        rd_byte = {d.gain_two, adc_overflow};
                    end
                    default: begin
                        rd_byte = 8'h00;
                    end
                endcase
            end
            d.reply   = {link_word[`CDC_WORD_W-1:`CDC_ADDR_LSB], rd_byte};
            d.ack_tgl = ~q.ack_tgl;
        end
        d.mon_mute  = mon_is_mute(q.ctrl_one[`CDC_MONG_MSB:`CDC_MONG_LSB]);
        d.mon_db    = mon_db_of(q.ctrl_one[`CDC_MONG_MSB:`CDC_MONG_LSB]);
        d.line_mute = pga_is_mute(
                          q.gain_two[`CDC_LING_MSB:`CDC_LING_LSB]);
        d.line_db   = pga_db_of(
                          q.gain_two[`CDC_LING_MSB:`CDC_LING_LSB],
                          1'b0);
        d.dac_mute  = pga_is_mute(
                          q.gain_two[`CDC_DACG_MSB:`CDC_DACG_LSB]);
        d.dac_db    = pga_db_of(
                          q.gain_two[`CDC_DACG_MSB:`CDC_DACG_LSB],
                          1'b1);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q          <= '0;
            q.ctrl_one <= `CDC_REG_RST;
            q.gain_two <= 7'(`CDC_REG_RST >> 1);
            q.mon_mute <= 1'b1;
            q.line_mute <= 1'b0;
            q.dac_mute <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign soft_reset          = q.ctrl_one[`CDC_SWRST_BIT];
    assign power_down          = q.ctrl_one[`CDC_PWDN_BIT];
    assign dig_loopback        = q.ctrl_one[`CDC_DLB_BIT];
    assign ana_loopback        = q.ctrl_one[`CDC_ALB_BIT];
    assign mon_src_line        = q.ctrl_one[`CDC_MONSRC_BIT];
    assign mon_gain_code       = q.ctrl_one[`CDC_MONG_MSB:`CDC_MONG_LSB];
    assign mon_mute            = q.mon_mute;
    assign mon_gain_db         = q.mon_db;
    assign line_input_pga_gain = q.gain_two[`CDC_LING_MSB:`CDC_LING_LSB];
    assign line_input_pga_mute = q.line_mute;
    assign line_input_pga_db   = q.line_db;
    assign dac_pga_gain        = q.gain_two[`CDC_DACG_MSB:`CDC_DACG_LSB];
    assign dac_pga_mute        = q.dac_mute;
    assign dac_pga_db          = q.dac_db;
    assign spk_gain_on         = q.gain_two[`CDC_SPK_BIT];

endmodule : cdc_ctrl_regs

// [tb/cdc_ctrl_regs_properties.sv]
`timescale 1ns/100ps

module cdc_checker (
    input wire logic             mclk,
    input wire logic             resetn,
    input wire logic             sclk,
    input wire logic             fs_n,
    input wire logic             dout_oe,
    input wire logic             soft_reset,
    input wire logic             power_down,
    input wire logic             dig_loopback,
    input wire logic             ana_loopback,
    input wire logic             mon_src_line,
    input wire logic [2:0]       mon_gain_code,
    input wire logic             mon_mute,
    input wire cdc_pkg::cdc_db_t mon_gain_db,
    input wire logic [2:0]       line_input_pga_gain,
    input wire logic             line_input_pga_mute,
    input wire cdc_pkg::cdc_db_t line_input_pga_db,
    input wire logic [2:0]       dac_pga_gain,
    input wire logic             dac_pga_mute,
    input wire cdc_pkg::cdc_db_t dac_pga_db,
    input wire logic             spk_gain_on
);
    import cdc_pkg::*;
    ////////////////////////////////////////
    // $stable waits out the one-cycle lag of the decoded gain outputs
    a_reset_zero: assert property (@(posedge mclk)
        disable iff (!resetn) $rose(resetn) |-> mon_mute &&
        {soft_reset, power_down, dig_loopback, ana_loopback, mon_src_line,
        mon_gain_code, line_input_pga_gain, dac_pga_gain, spk_gain_on} == 0)
        else $error("registers not clear after reset");
    a_mon_mute_map: assert property (@(posedge mclk)
        disable iff (!resetn) $stable(mon_gain_code) |->
        mon_mute == !(mon_gain_code inside {[3'h1:3'h5]}))
        else $error("monitor mute wrong for code");
    a_mon_db_map: assert property (@(posedge mclk)
        disable iff (!resetn) $stable(mon_gain_code) && !mon_mute |->
        mon_gain_db == 6'(3 * (int'(mon_gain_code) - 1)))
        else $error("monitor gain wrong for code");
    a_line_mute_map: assert property (@(posedge mclk)
        disable iff (!resetn) $stable(line_input_pga_gain) |->
        line_input_pga_mute == line_input_pga_gain[2])
        else $error("line input mute wrong for code");
    a_line_db_map: assert property (@(posedge mclk)
        disable iff (!resetn) $stable(line_input_pga_gain) |->
        line_input_pga_db == (line_input_pga_gain[2] ? 6'h00 :
        6'(6 * int'(line_input_pga_gain))))
        else $error("line input gain wrong for code");
    a_dac_mute_map: assert property (@(posedge mclk)
        disable iff (!resetn) $stable(dac_pga_gain) |->
        dac_pga_mute == dac_pga_gain[2])
        else $error("dac mute wrong for code");
    a_dac_db_map: assert property (@(posedge mclk)
        disable iff (!resetn) $stable(dac_pga_gain) |->
        dac_pga_db == (dac_pga_gain[2] ? 6'h00 :
        6'(-6 * int'(dac_pga_gain))))
        else $error("dac gain wrong for code");
    a_reply_drive: assert property (@(posedge sclk)
        disable iff (!resetn) dout_oe == !fs_n)
        else $error("reply driver enable not tied to frame");
endmodule : cdc_checker

bind cdc_ctrl_regs cdc_checker i_checker (.mclk, .resetn, .sclk, .fs_n,
    .dout_oe, .soft_reset, .power_down, .dig_loopback, .ana_loopback,
    .mon_src_line, .mon_gain_code, .mon_mute, .mon_gain_db,
    .line_input_pga_gain, .line_input_pga_mute, .line_input_pga_db,
    .dac_pga_gain, .dac_pga_mute, .dac_pga_db, .spk_gain_on);

// [tb/cdc_host_model.sv]
`timescale 1ns/100ps

module cdc_host_model (
    output logic      sclk,
    output logic      fs_n,
    output logic      din,
    input  wire logic dout
);
    initial begin
        sclk = 1'b0;
        fs_n = 1'b1;
        din  = 1'b0;
        forever #24 sclk = ~sclk;
    end
    ////////////////////////////////////////
    // reply bits belong to the previous word, so callers pair frames
    task automatic xfer(input logic [15:0] w, output logic [15:0] rep);
        for (int i = 15; i >= 0; i--) begin
            @(negedge sclk);
            fs_n   = 1'b0;
            din    = w[i];
            rep[i] = dout;
        end
        @(negedge sclk);
        fs_n = 1'b1;
        din  = ~w[0];
        // long gap lets the answer cross back before the next frame
        repeat (24) @(negedge sclk);
    endtask : xfer
endmodule : cdc_host_model

// [tb/testbench.sv]
`timescale 1ns/100ps

module testbench;
    import cdc_pkg::*;
    logic        mclk, resetn, adc_overflow, sclk, fs_n, din, dout, dout_oe;
    logic        soft_reset, power_down, dig_loopback, ana_loopback;
    logic        mon_src_line, mon_mute, line_input_pga_mute, dac_pga_mute;
    logic        spk_gain_on, mute;
    logic [2:0]  mon_gain_code, line_input_pga_gain, dac_pga_gain;
    cdc_db_t     mon_gain_db, line_input_pga_db, dac_pga_db;
    logic [15:0] r;
    logic [7:0]  v, d;
    int          fail_count = 0;
    int          n_tests = 0;
    wire  [7:0]  ctl = {soft_reset, power_down, dig_loopback, ana_loopback,
                        mon_src_line, mon_gain_code};
    wire  [6:0]  g2 = {line_input_pga_gain, dac_pga_gain, spk_gain_on};

    cdc_ctrl_regs i_dut (.mclk, .resetn, .sclk, .fs_n, .din, .dout, .dout_oe,
        .adc_overflow, .soft_reset, .power_down, .dig_loopback, .ana_loopback,
        .mon_src_line, .mon_gain_code, .mon_mute, .mon_gain_db,
        .line_input_pga_gain, .line_input_pga_mute, .line_input_pga_db,
        .dac_pga_gain, .dac_pga_mute, .dac_pga_db, .spk_gain_on);
    cdc_host_model i_host (.sclk, .fs_n, .din, .dout);
    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic access(input logic [15:0] w, output logic [15:0] rep);
        logic [15:0] junk;
        i_host.xfer(w, junk);
        i_host.xfer(16'h2000, rep);
    endtask : access
    task automatic wr(input logic [4:0] a, input logic [7:0] dat);
        access({3'b000, a, dat}, r);
        check(r[15:8], {3'b000, a});
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] dat);
        access({3'b001, a, 8'h00}, r);
        check(r[15:8], {3'b001, a});
        dat = r[7:0];
    endtask : rd
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        resetn       = 1'b0;
        adc_overflow = 1'b0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        check({ctl, g2, mon_mute}, 16'h0001);
        // link must see sync high on a clock edge out of reset first
        repeat (2) @(negedge mclk);
        rd(5'h01, v);
        check(v, 8'h00);
        rd(5'h02, v);
        check(v, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = {i[0] ? 5'h15 : 5'h0A, 3'(i)};
            wr(5'h01, d);
            mute = !(i inside {[1:5]});
            check(ctl, d);
            check({mon_mute, mon_gain_db},
                  {mute, mute ? 6'h00 : 6'(3 * (i - 1))});
            rd(5'h01, v);
            check(v, d);
        end
        $display("control one test done");
        for (int i = 0; i < 5; i++) begin
            // bit 0 written high must not stick
            d = {3'(i), 3'(i), i[0], 1'b1};
            wr(5'h02, d);
            mute = (i == 4);
            check(g2, d[7:1]);
            check({line_input_pga_mute, line_input_pga_db},
                  {mute, mute ? 6'h00 : 6'(6 * i)});
            check({dac_pga_mute, dac_pga_db},
                  {mute, mute ? 6'h00 : 6'(-6 * i)});
            rd(5'h02, v);
            check(v, {d[7:1], 1'b0});
        end
        $display("control two test done");
        @(negedge mclk);
        adc_overflow = 1'b1;
        rd(5'h02, v);
        check(v[0], 1'b1);
        @(negedge mclk);
        adc_overflow = 1'b0;
        rd(5'h02, v);
        check(v[0], 1'b0);
        $display("overflow test done");
        access(16'h41FF, r);
        access(16'h03FF, r);
        check(r[7:0], 8'h00);
        rd(5'h01, v);
        check({ctl, v}, 16'hAFAF);
        $display("refusal test done");
        @(negedge mclk);
        resetn = 1'b0;
        repeat (20) @(negedge mclk);
        resetn = 1'b1;
        check({ctl, g2}, 15'h0000);
        repeat (2) @(negedge mclk);
        rd(5'h01, v);
        check(v, 8'h00);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule : testbench
